// *** pkg/bcbx_consts.svh ***
// constants for the bit-clear and conditional-branch execute block
// How it works
// - The bit-clear opcode 1001 bbba ffff ffff forces bit b of the addressed register to 0.
// - Access bit 0 addresses the access bank, access bit 1 takes the bank from bank_pointer.
// - Access bit 0 with extended set enabled and operand at most 5Fh uses indexed offset.
// - Opcode 1110 0110 nnnn nnnn branches only when the negative flag is 1, no flag changes.
// - A taken branch loads the branch address plus 2 plus twice the signed 8-bit offset.
// - A taken branch lasts two cycles, PC written in Q4 of the first, second cycle all nop.
// - Opcode 1110 0010 nnnn nnnn branches only when the carry flag is 1.
`ifndef BCBX_CONSTS_SVH
`define BCBX_CONSTS_SVH

`define BCBX_PC_W        21
`define BCBX_ADDR_W      12
`define BCBX_BANK_W      4
`define BCBX_OP_BITZ     4'h9
`define BCBX_OP_BMINUS   8'he6
`define BCBX_OP_BCARRY   8'he2
`define BCBX_ILO_MAX     8'h5f
`define BCBX_ACC_LO_BANK 4'h0
`define BCBX_ACC_HI_BANK 4'hf
`define BCBX_PC_STEP     21'h000002
`define BCBX_PC_RST      21'h000000
`define BCBX_ADDR_RST    12'h000
`define BCBX_DATA_RST    8'h00

`endif

// *** pkg/bcbx_pkg.sv ***
// types for the bit-clear and conditional-branch execute block
package bcbx_pkg;

   typedef enum logic [1:0] {
      BCBX_Q1 = 2'b00,
      BCBX_Q2 = 2'b01,
      BCBX_Q3 = 2'b10,
      BCBX_Q4 = 2'b11
   } bcbx_phase_t;

   typedef enum logic [1:0] {
      BCBX_OP_NONE   = 2'b00,
      BCBX_OP_BITZ   = 2'b01,
      BCBX_OP_BRANCH = 2'b10
   } bcbx_op_t;

   typedef struct packed {
      logic        we;
      logic [11:0] addr;
      logic [7:0]  data;
   } bcbx_rf_wr_t;

   typedef struct packed {
      logic        we;
      logic [20:0] target;
   } bcbx_pc_wr_t;

endpackage

// *** src/bcbx_exec.sv ***
// execute logic for bit clear and branch-on-negative / branch-on-carry
`timescale 1ns/1ps
`include "bcbx_consts.svh"

module bcbx_exec (
   // clock and reset
   input  wire logic                      CLK_I,
   input  wire logic                      SRST_I,
   // instruction from fetch, sampled in Q1
   input  wire logic                      INSTR_VALID_I,
   input  wire logic [15:0]               INSTR_I,
   input  wire logic [`BCBX_PC_W-1:0]     PC_I,
   // core state
   input  wire logic                      NEG_I,
   input  wire logic                      CARRY_I,
   input  wire logic [`BCBX_BANK_W-1:0]   BANK_PTR_I,
   input  wire logic                      XINST_EN_I,
   input  wire logic [`BCBX_ADDR_W-1:0]   INDEX_BASE_I,
   // register file read, data sampled at end of Q2
   output logic      [`BCBX_ADDR_W-1:0]   RF_RADDR_O,
   input  wire logic [7:0]                RF_RDATA_I,
   // register file write, valid in Q4
   output bcbx_pkg::bcbx_rf_wr_t          RF_WR_O,
   // program counter write, valid in Q4
   output bcbx_pkg::bcbx_pc_wr_t          PC_WR_O,
   // phase and pipeline state
   output bcbx_pkg::bcbx_phase_t          PHASE_O,
   output logic                           NOP_CYCLE_O
);

   ////////////////////////////////////////////////////////////////////////////////
   // phase sequencer

   bcbx_pkg::bcbx_phase_t q_r;
   bcbx_pkg::bcbx_phase_t q_nxt;

   // four clocks per instruction cycle, Q1 to Q4 and round again
   always_comb begin
      case (q_r)
         bcbx_pkg::BCBX_Q1: begin
            q_nxt = bcbx_pkg::BCBX_Q2;
         end
         bcbx_pkg::BCBX_Q2: begin
            q_nxt = bcbx_pkg::BCBX_Q3;
         end
         bcbx_pkg::BCBX_Q3: begin
            q_nxt = bcbx_pkg::BCBX_Q4;
         end
         bcbx_pkg::BCBX_Q4: begin
            q_nxt = bcbx_pkg::BCBX_Q1;
         end
         default: begin
            q_nxt = bcbx_pkg::BCBX_Q1;
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         q_r <= bcbx_pkg::BCBX_Q1;
      end else begin
         q_r <= q_nxt;
      end
   end

   wire in_q1 = (q_r == bcbx_pkg::BCBX_Q1);
   wire in_q2 = (q_r == bcbx_pkg::BCBX_Q2);
   wire in_q3 = (q_r == bcbx_pkg::BCBX_Q3);
   wire in_q4 = (q_r == bcbx_pkg::BCBX_Q4);

   ////////////////////////////////////////////////////////////////////////////////
   // decode (Q1)

   logic nop_r;

   wire [7:0] f_field   = INSTR_I[7:0];
   wire       acc_bit   = INSTR_I[8];
   wire [2:0] bit_field = INSTR_I[11:9];
   wire       take_instr = in_q1 && INSTR_VALID_I && !nop_r;

   wire is_bitz   = (INSTR_I[15:12] == `BCBX_OP_BITZ);
   wire is_bminus = (INSTR_I[15:8]  == `BCBX_OP_BMINUS);
   wire is_bcarry = (INSTR_I[15:8]  == `BCBX_OP_BCARRY);

   // flags are only read here; this block has no path that writes status
   wire br_cond = (is_bminus && NEG_I) || (is_bcarry && CARRY_I);

   wire use_ilo   = !acc_bit && XINST_EN_I && (f_field <= `BCBX_ILO_MAX);
   wire [`BCBX_ADDR_W-1:0] ilo_addr = INDEX_BASE_I + {4'h0, f_field};
   wire [`BCBX_BANK_W-1:0] acc_bank =
      (f_field <= `BCBX_ILO_MAX) ? `BCBX_ACC_LO_BANK : `BCBX_ACC_HI_BANK;
   wire [`BCBX_ADDR_W-1:0] dir_addr =
      acc_bit ? {BANK_PTR_I, f_field} : {acc_bank, f_field};
   wire [`BCBX_ADDR_W-1:0] eff_addr = use_ilo ? ilo_addr : dir_addr;

   // target = branch address + 2 + 2n, n sign extended
   wire [`BCBX_PC_W-1:0] offs2 =
      {{(`BCBX_PC_W-9){INSTR_I[7]}}, INSTR_I[7:0], 1'b0};
   wire [`BCBX_PC_W-1:0] br_target = PC_I + `BCBX_PC_STEP + offs2;

   bcbx_pkg::bcbx_op_t op_r;
   bcbx_pkg::bcbx_op_t op_nxt;
   logic [2:0]               bit_r;
   logic [`BCBX_ADDR_W-1:0]  addr_r;
   logic [`BCBX_PC_W-1:0]    target_r;
   logic                     taken_r;

   logic [2:0]               bit_nxt;
   logic [`BCBX_ADDR_W-1:0]  addr_nxt;
   logic [`BCBX_PC_W-1:0]    target_nxt;
   logic                     taken_nxt;

   // a Q1 with nothing taken leaves no op behind, so an old op never runs twice
   assign op_nxt = !take_instr ? bcbx_pkg::BCBX_OP_NONE :
                   is_bitz ? bcbx_pkg::BCBX_OP_BITZ :
                   (is_bminus || is_bcarry) ? bcbx_pkg::BCBX_OP_BRANCH :
                   bcbx_pkg::BCBX_OP_NONE;
   assign bit_nxt    = take_instr ? bit_field : bit_r;
   assign addr_nxt   = take_instr ? eff_addr : addr_r;
   assign target_nxt = take_instr ? br_target : target_r;
   assign taken_nxt  = take_instr && br_cond;

   // op and branch decision
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         op_r    <= bcbx_pkg::BCBX_OP_NONE;
         taken_r <= 1'b0;
      end else if (in_q1) begin
         op_r    <= op_nxt;
         taken_r <= taken_nxt;
      end
   end

   // operands, held until the next taken Q1
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         bit_r    <= 3'h0;
         addr_r   <= `BCBX_ADDR_RST;
         target_r <= `BCBX_PC_RST;
      end else if (in_q1) begin
         bit_r    <= bit_nxt;
         addr_r   <= addr_nxt;
         target_r <= target_nxt;
      end
   end

   // an idle or ignored Q1 clears the op so nothing stale executes
   wire op_bitz   = (op_r == bcbx_pkg::BCBX_OP_BITZ) && !nop_r;
   wire op_branch = (op_r == bcbx_pkg::BCBX_OP_BRANCH) && !nop_r;

   ////////////////////////////////////////////////////////////////////////////////
   // register read (Q2) and bit clear (Q3)

   logic [7:0] rdata_r;
   logic [7:0] wdata_r;
   logic [7:0] clr_mask;

   always_comb begin
      clr_mask = 8'hff;
      clr_mask[bit_r] = 1'b0;
   end

   wire [7:0] cleared = rdata_r & clr_mask;

   logic [7:0] rdata_nxt;
   logic [7:0] wdata_nxt;

   assign rdata_nxt = in_q2 ? RF_RDATA_I : rdata_r;
   assign wdata_nxt = in_q3 ? cleared : wdata_r;

   // operand byte, taken at the end of Q2
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         rdata_r <= `BCBX_DATA_RST;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // write byte with one bit forced low, formed at the end of Q3
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         wdata_r <= `BCBX_DATA_RST;
      end else begin
         wdata_r <= wdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // write strobes (Q4) and nop cycle

   logic rf_we_r;
   logic pc_we_r;
   logic nop_nxt;
   logic rf_we_nxt;
   logic pc_we_nxt;

   // strobes rise at the end of Q3 so each stands for the Q4 clock alone
   assign rf_we_nxt = in_q3 && op_bitz;
   // a branch not taken leaves the PC alone
   assign pc_we_nxt = in_q3 && op_branch && taken_r;

   // a taken branch marks the whole next instruction cycle as nop
   assign nop_nxt = in_q4 ? (op_branch && taken_r) : nop_r;

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         rf_we_r <= 1'b0;
         pc_we_r <= 1'b0;
         nop_r   <= 1'b0;
      end else begin
         rf_we_r <= rf_we_nxt;
         pc_we_r <= pc_we_nxt;
         nop_r   <= nop_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign RF_RADDR_O     = addr_r;
   assign RF_WR_O.we     = rf_we_r;
   assign RF_WR_O.addr   = addr_r;
   assign RF_WR_O.data   = wdata_r;
   assign PC_WR_O.we     = pc_we_r;
   assign PC_WR_O.target = target_r;
   assign PHASE_O        = q_r;
   assign NOP_CYCLE_O    = nop_r;

endmodule

// *** tb/bcbx_checker.sv ***
// port assertions for bcbx_exec
`timescale 1ns/1ps
module bcbx_checker (
   // clock and reset
   input wire logic          CLK_I,
   input wire logic          SRST_I,
   // instruction and flags
   input wire logic          INSTR_VALID_I,
   input wire logic [15:0]   INSTR_I,
   input wire logic [20:0]   PC_I,
   input wire logic          NEG_I,
   input wire logic          CARRY_I,
   // outputs
   input bcbx_pkg::bcbx_rf_wr_t RF_WR_O,
   input bcbx_pkg::bcbx_pc_wr_t PC_WR_O,
   input bcbx_pkg::bcbx_phase_t PHASE_O,
   input wire logic          NOP_CYCLE_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   wire       go = PHASE_O == bcbx_pkg::BCBX_Q1 && INSTR_VALID_I && !NOP_CYCLE_O;
   wire [7:0] op = INSTR_I[15:8];
   wire [2:0] bx = INSTR_I[11:9];
   chk_phase_step: assert property (1 |=> PHASE_O == $past(PHASE_O) + 2'h1)
      else $error("phase did not advance");
   chk_rf_q4: assert property (RF_WR_O.we |-> PHASE_O == bcbx_pkg::BCBX_Q4)
      else $error("register write outside q4");
   chk_pc_q4: assert property (PC_WR_O.we |-> PHASE_O == bcbx_pkg::BCBX_Q4)
      else $error("pc write outside q4");
   chk_nop_len: assert property (PC_WR_O.we |=> NOP_CYCLE_O [*4] ##1 !NOP_CYCLE_O)
      else $error("nop cycle length wrong");
   chk_nop_quiet: assert property (NOP_CYCLE_O |-> !RF_WR_O.we && !PC_WR_O.we)
      else $error("write in nop cycle");
   chk_minus_take: assert property (go && op == 8'he6 |-> ##3 PC_WR_O.we == $past(NEG_I, 3))
      else $error("minus branch wrong");
   chk_carry_take: assert property (go && op == 8'he2 |-> ##3 PC_WR_O.we == $past(CARRY_I, 3))
      else $error("carry branch wrong");
   chk_bit_clear: assert property (go && op[7:4] == 4'h9 |-> ##3 RF_WR_O.we && !RF_WR_O.data[$past(bx, 3)])
      else $error("bit not cleared");
   wire        bitz_go = go && op[7:4] == 4'h9;
   wire        br_go   = go && (op == 8'he6 && NEG_I || op == 8'he2 && CARRY_I);
   wire [20:0] tgt     = PC_I + 21'h2 + {{12{INSTR_I[7]}}, INSTR_I[7:0], 1'b0};
   chk_rf_source: assert property (RF_WR_O.we |-> $past(bitz_go, 3))
      else $error("register write without a bit clear");
   chk_br_target: assert property (br_go |-> ##3 PC_WR_O.target == $past(tgt, 3))
      else $error("branch target wrong");
endmodule
bind bcbx_exec bcbx_checker bcbx_checker_inst (.*);

// *** tb/bcbx_rf_model.sv ***
// register file model behind the read and write ports
`timescale 1ns/1ps
module bcbx_rf_model (
   // clock and ports
   input wire logic             clk_i,
   input wire logic [11:0]      raddr_i,
   output logic     [7:0]       rdata_o,
   input bcbx_pkg::bcbx_rf_wr_t wr_i
);
   logic [7:0] mem [4096];
   initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'ha5;
   assign rdata_o = mem[raddr_i];
   always @(posedge clk_i) if (wr_i.we) mem[wr_i.addr] <= wr_i.data;
endmodule

// *** tb/tb_top.sv ***
// testbench for bcbx_exec
`timescale 1ns/1ps
module tb_top;
   logic CLK_I = 0, SRST_I = 1, vld = 0, neg = 0, cy = 0, xen = 0, nop;
   logic [15:0] ins = 16'h0000;
   logic [20:0] pc = 21'h0;
   logic [3:0]  bank = 4'h0;
   logic [11:0] base = 12'h200, raddr;
   logic [7:0]  rdata;
   bcbx_pkg::bcbx_rf_wr_t rf_wr;
   bcbx_pkg::bcbx_pc_wr_t pc_wr;
   bcbx_pkg::bcbx_phase_t phase;
   int mismatches = 0, n_compared = 0;
   always #20 CLK_I = ~CLK_I;
   bcbx_exec bcbx_exec_inst (.CLK_I(CLK_I), .SRST_I(SRST_I), .INSTR_VALID_I(vld),
      .INSTR_I(ins), .PC_I(pc), .NEG_I(neg), .CARRY_I(cy), .BANK_PTR_I(bank),
      .XINST_EN_I(xen), .INDEX_BASE_I(base), .RF_RADDR_O(raddr), .RF_RDATA_I(rdata),
      .RF_WR_O(rf_wr), .PC_WR_O(pc_wr), .PHASE_O(phase), .NOP_CYCLE_O(nop));
   bcbx_rf_model bcbx_rf_model_inst (.clk_i(CLK_I), .raddr_i(raddr), .rdata_o(rdata),
      .wr_i(rf_wr));
   task automatic chk(string s, logic [20:0] e, logic [20:0] g);
      n_compared++;
      if (e !== g) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask
   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // present one word in q1, return at the q4 of its cycle
   task automatic issue(logic [15:0] i);
      for (int k = 0; k < 8 && phase !== bcbx_pkg::BCBX_Q1; k++) @(negedge CLK_I);
      ins = i;
      vld = 1;
      repeat (3) begin
         @(negedge CLK_I);
         vld = 0;
      end
   endtask
   task automatic sc_bitz(logic [15:0] i, logic [3:0] bk, logic x, logic [11:0] ad);
      bank = bk;
      xen = x;
      issue(i);
      chk("rf we", 1, rf_wr.we);
      chk("rf raddr", ad, raddr);
      chk("rf addr", ad, rf_wr.addr);
      chk("rf data", 8'((ad[7:0] ^ 8'ha5) & ~(8'h01 << i[11:9])), rf_wr.data);
   endtask
   // called at a q4: idle cycle, off-phase word, then an opcode this block ignores
   task automatic sc_quiet();
      neg = 1;
      cy = 1;
      repeat (4) @(negedge CLK_I);
      chk("idle we", 0, rf_wr.we);
      repeat (2) @(negedge CLK_I);
      ins = 16'h9f55;
      vld = 1;
      @(negedge CLK_I);
      vld = 0;
      @(negedge CLK_I);
      chk("off phase we", 0, rf_wr.we);
      issue(16'he310);
      chk("other op pc we", 0, pc_wr.we);
      chk("other op rf we", 0, rf_wr.we);
   endtask
   task automatic sc_br(logic [7:0] op, logic f, logic [7:0] n, logic [20:0] p);
      neg = f ^ (op == 8'he2);
      cy = ~neg;
      pc = p;
      issue({op, n});
      chk("pc we", f, pc_wr.we);
      if (f) begin
         chk("target", p + 21'h2 + {{12{n[7]}}, n, 1'b0}, pc_wr.target);
         issue(16'h9f40);
         chk("nop", 1, nop);
         chk("flushed we", 0, rf_wr.we);
         @(negedge CLK_I);
         chk("nop end", 0, nop);
      end else begin
         @(negedge CLK_I);
         chk("no nop", 0, nop);
      end
   endtask
   initial begin
      repeat (16) @(negedge CLK_I);
      SRST_I = 0;
      sc_bitz(16'h9f12, 4'h3, 1'b0, 12'h312);
      sc_bitz(16'h9010, 4'h3, 1'b1, 12'h210);
      sc_bitz(16'h925f, 4'h3, 1'b1, 12'h25f);
      sc_bitz(16'h9460, 4'h3, 1'b1, 12'hf60);
      sc_bitz(16'h9620, 4'h3, 1'b0, 12'h020);
      sc_bitz(16'h9ca0, 4'h3, 1'b0, 12'hfa0);
      sc_bitz(16'h9930, 4'h5, 1'b1, 12'h530);
      sc_quiet();
      sc_br(8'he6, 1'b1, 8'h05, 21'h000100);
      sc_br(8'he6, 1'b0, 8'h05, 21'h000100);
      sc_br(8'he2, 1'b1, 8'h80, 21'h000200);
      sc_br(8'he2, 1'b0, 8'h7f, 21'h000300);
      finish_test;
   end
   initial begin
      #20000;
      mismatches++;
      finish_test;
   end
endmodule
